// file: logic/gpd_top.sv
// Four-port GPIO register file with pads, pull-ups and analog enables
// Function
// - Data register writes drive only pins configured as outputs.
// - Output pin reads return the stored data bit.
// - Input pin reads return the pad level, not the stored bit.
// - Enabled port synchronisers feed reads instead of raw pads.
// - Sync enable register holds one bit per port, low nibble, resets zero.
// - Each pin has a pull-up enable bit; ports 0 to 2 reset off.
// - Port 3 pull-ups reset enabled on pins 2 and 3 only.
// - Push-pull output pins have pull-up forced off.
// - Open-drain pins driving low have pull-up forced off.
// - Port 0 analog enable register has eight bits, resets zero.
// - Port 1 analog enable implements bit 2 only, resets zero.
// - Port 3 analog enable implements bit 0 only, resets zero.
// - Enabled peripheral takes over its shared pin.
// - Four read-write data registers at 80, 90, A0, B0.
// - Direction resets to one; zero means output or input buffer off.
// - Open-drain select resets zero; one selects open-drain drive.
`timescale 1ns/10ps
`default_nettype none
module gpd_top
  import gpd_pkg::*;
(
  // Clock and reset
  input  wire logic        clock,
  input  wire logic        reset_n,
  // Special-function-register access
  input  wire logic [7:0]  sfr_addr,
  input  wire logic [7:0]  sfr_wdata,
  input  wire logic        sfr_wr,
  input  wire logic        sfr_rd,
  output logic      [7:0]  sfr_rdata,
  // Pads
  input  wire logic [31:0] pad_in,
  output logic      [31:0] pad_out,
  output logic      [31:0] pad_oe,
  output logic      [31:0] pad_pullup_en,
  output logic      [31:0] pad_inbuf_en,
  output logic      [31:0] pin_analog_enable,
  // Shared peripherals
  input  wire logic [31:0] periph_sel,
  input  wire logic [31:0] periph_out,
  input  wire logic [31:0] periph_oe
);

  // ==========================================================
  // Register storage
  gpd_byte_t  port_data_reg  [NUM_PORTS];
  gpd_byte_t  pin_direction_reg [NUM_PORTS];
  gpd_byte_t  pin_opendrain_select_reg [NUM_PORTS];
  gpd_byte_t  pin_pullup_enable_reg [NUM_PORTS];
  logic [3:0] input_sync_enable_reg;
  gpd_byte_t  port0_analog_enable_reg;
  logic       port_one_pin_two_analog_en_reg;
  logic       port_three_pin_zero_analog_en_reg;
  gpd_byte_t  rdata_reg;

  // Address decode
  logic [NUM_PORTS-1:0] hit_data;
  logic [NUM_PORTS-1:0] hit_dir;
  logic [NUM_PORTS-1:0] hit_od;
  logic [NUM_PORTS-1:0] hit_pup;
  logic                 hit_sync;
  logic                 hit_aie0;
  logic                 hit_aie1;
  logic                 hit_aie3;
  gpd_byte_t            port_rd [NUM_PORTS];
  gpd_byte_t            rd_mux;

  gpd_port_if port_if [NUM_PORTS] ();

  // ==========================================================
  // Decode of fixed addresses
  assign hit_sync = (sfr_addr == ADDR_SYNC);
  assign hit_aie0 = (sfr_addr == ADDR_AIE0);
  assign hit_aie1 = (sfr_addr == ADDR_AIE1);
  assign hit_aie3 = (sfr_addr == ADDR_AIE3);

  // ==========================================================
  // Per-port decode, slice hookup and pad flattening
  for (genvar p = 0; p < NUM_PORTS; p++) begin : g_port
    // Register hits for this port
    assign hit_data[p] = (sfr_addr == ADDR_DATA[p]);
    assign hit_dir[p]  = (sfr_addr == ADDR_DIR[p]);
    assign hit_od[p]   = (sfr_addr == ADDR_OD[p]);
    assign hit_pup[p]  = (sfr_addr == ADDR_PUP[p]);

    // Settings toward the slice
    assign port_if[p].data    = port_data_reg[p];
    assign port_if[p].dir     = pin_direction_reg[p];
    assign port_if[p].od      = pin_opendrain_select_reg[p];
    assign port_if[p].pup     = pin_pullup_enable_reg[p];
    assign port_if[p].sync_en = input_sync_enable_reg[p];
    assign port_if[p].sel     = periph_sel[p*8 +: 8];
    assign port_if[p].p_out   = periph_out[p*8 +: 8];
    assign port_if[p].p_oe    = periph_oe[p*8 +: 8];
    assign port_if[p].pad_in  = pad_in[p*8 +: 8];

    // Results back to pads and read path
    assign port_rd[p]              = port_if[p].rd_val;
    assign pad_out[p*8 +: 8]       = port_if[p].pad_out;
    assign pad_oe[p*8 +: 8]        = port_if[p].pad_oe;
    assign pad_pullup_en[p*8 +: 8] = port_if[p].pull_en;
    assign pad_inbuf_en[p*8 +: 8]  = port_if[p].inbuf_en;

    gpd_pin_slice u_slice (
      .clock   (clock),
      .reset_n (reset_n),
      .pif     (port_if[p])
    );

    // Written data shows on push-pull outputs next cycle
    property p_wr_drives;
      @(posedge clock) disable iff (!reset_n)
      sfr_wr && hit_data[p]
      |=> ((pad_out[p*8 +: 8] ^ $past(sfr_wdata))
           & ~pin_direction_reg[p] & ~pin_opendrain_select_reg[p]
           & ~periph_sel[p*8 +: 8]) == 8'h00;
    endproperty
    a_wr_drives: assert property (p_wr_drives) else $error("output pin misses written data");

    // Push-pull inputs are never driven
    property p_in_undriven;
      @(posedge clock) disable iff (!reset_n)
      (pin_direction_reg[p] & ~pin_opendrain_select_reg[p]) != 8'h00
      |-> (pad_oe[p*8 +: 8] & pin_direction_reg[p]
           & ~pin_opendrain_select_reg[p] & ~periph_sel[p*8 +: 8]) == 8'h00;
    endproperty
    a_in_undriven: assert property (p_in_undriven) else $error("input pin is driven");

    // Output pins read back the stored bit
    property p_rd_output;
      @(posedge clock) disable iff (!reset_n)
      sfr_rd && hit_data[p]
      |=> ((sfr_rdata ^ $past(port_data_reg[p]))
           & $past(~pin_direction_reg[p] & ~pin_opendrain_select_reg[p])) == 8'h00;
    endproperty
    a_rd_output: assert property (p_rd_output) else $error("output pin read wrong");

    // Input pins read the raw pad while sync is off
    property p_rd_raw;
      @(posedge clock) disable iff (!reset_n)
      sfr_rd && hit_data[p] && !input_sync_enable_reg[p]
      |=> ((sfr_rdata ^ $past(pad_in[p*8 +: 8])) & $past(pin_direction_reg[p])) == 8'h00;
    endproperty
    a_rd_raw: assert property (p_rd_raw) else $error("input pin read not pad level");

    // With sync on, reads see the pad two cycles late
    property p_rd_sync;
      @(posedge clock) disable iff (!reset_n)
      sfr_rd && hit_data[p] && input_sync_enable_reg[p]
      |=> ((sfr_rdata ^ $past(pad_in[p*8 +: 8], 3)) & $past(pin_direction_reg[p])) == 8'h00;
    endproperty
    a_rd_sync: assert property (p_rd_sync) else $error("synchronised read wrong");

    // Open-drain with input buffer off reads zero
    property p_rd_od_off;
      @(posedge clock) disable iff (!reset_n)
      sfr_rd && hit_data[p]
      |=> (sfr_rdata & $past(~pin_direction_reg[p] & pin_opendrain_select_reg[p])) == 8'h00;
    endproperty
    a_rd_od_off: assert property (p_rd_od_off) else $error("disabled input buffer read nonzero");

    // Push-pull outputs have no pull-up; inputs follow the enable bit
    property p_pull_pp;
      @(posedge clock) disable iff (!reset_n)
      sfr_wr && hit_pup[p]
      |=> ((pad_pullup_en[p*8 +: 8] ^ ($past(sfr_wdata) & pin_direction_reg[p]))
           & ~pin_opendrain_select_reg[p] & ~periph_sel[p*8 +: 8]) == 8'h00;
    endproperty
    a_pull_pp: assert property (p_pull_pp) else $error("push-pull pull-up wrong");

    // Open-drain low drive kills the pull-up
    property p_pull_od;
      @(posedge clock) disable iff (!reset_n)
      sfr_wr && hit_data[p]
      |=> (pad_pullup_en[p*8 +: 8] & pin_opendrain_select_reg[p]
           & ~$past(sfr_wdata) & ~periph_sel[p*8 +: 8]) == 8'h00;
    endproperty
    a_pull_od: assert property (p_pull_od) else $error("pull-up on while pulling low");

    // Peripheral owns the pin when selected
    property p_periph;
      @(posedge clock) disable iff (!reset_n)
      periph_sel[p*8 +: 8] != 8'h00
      |-> ((pad_oe[p*8 +: 8] ^ periph_oe[p*8 +: 8]) & periph_sel[p*8 +: 8]) == 8'h00
          && ((pad_out[p*8 +: 8] ^ periph_out[p*8 +: 8]) & periph_sel[p*8 +: 8]) == 8'h00;
    endproperty
    a_periph: assert property (p_periph) else $error("peripheral lost its pin");
  end

  // ==========================================================
  // Register writes; one address per cycle, last write wins
  always_ff @(posedge clock) begin
    if (!reset_n) begin
      for (int p = 0; p < NUM_PORTS; p++) begin
        port_data_reg[p]            <= RST_DATA;
        pin_direction_reg[p]        <= RST_DIR;
        pin_opendrain_select_reg[p] <= RST_OD;
        pin_pullup_enable_reg[p]    <= RST_PUP[p];
      end
    end else if (sfr_wr) begin
      for (int p = 0; p < NUM_PORTS; p++) begin
        if (hit_data[p]) begin
          port_data_reg[p] <= sfr_wdata;
        end
        if (hit_dir[p]) begin
          pin_direction_reg[p] <= sfr_wdata;
        end
        if (hit_od[p]) begin
          pin_opendrain_select_reg[p] <= sfr_wdata;
        end
        if (hit_pup[p]) begin
          pin_pullup_enable_reg[p] <= sfr_wdata;
        end
      end
    end
  end

  // Sync and analog enables; unimplemented bits are not stored
  always_ff @(posedge clock) begin
    if (!reset_n) begin
      input_sync_enable_reg             <= RST_SYNC;
      port0_analog_enable_reg           <= RST_AIE;
      port_one_pin_two_analog_en_reg    <= 1'b0;
      port_three_pin_zero_analog_en_reg <= 1'b0;
    end else if (sfr_wr) begin
      if (hit_sync) begin
        input_sync_enable_reg <= sfr_wdata[3:0];
      end
      if (hit_aie0) begin
        port0_analog_enable_reg <= sfr_wdata;
      end
      if (hit_aie1) begin
        port_one_pin_two_analog_en_reg <= sfr_wdata[AIE1_BIT];
      end
      if (hit_aie3) begin
        port_three_pin_zero_analog_en_reg <= sfr_wdata[AIE3_BIT];
      end
    end
  end

  // ==========================================================
  // Analog channel enables; port 2 has none
  assign pin_analog_enable[7:0]   = port0_analog_enable_reg;
  assign pin_analog_enable[15:8]  = {5'h00, port_one_pin_two_analog_en_reg, 2'h0};
  assign pin_analog_enable[23:16] = 8'h00;
  assign pin_analog_enable[31:24] = {7'h00, port_three_pin_zero_analog_en_reg};

  // ==========================================================
  // Read mux; unmapped addresses read zero
  always_comb begin
    rd_mux = RD_NONE;
    for (int p = 0; p < NUM_PORTS; p++) begin
      if (hit_data[p]) begin
        rd_mux = port_rd[p];
      end
      if (hit_dir[p]) begin
        rd_mux = pin_direction_reg[p];
      end
      if (hit_od[p]) begin
        rd_mux = pin_opendrain_select_reg[p];
      end
      if (hit_pup[p]) begin
        rd_mux = pin_pullup_enable_reg[p];
      end
    end
    if (hit_sync) begin
      rd_mux = {4'h0, input_sync_enable_reg};
    end
    if (hit_aie0) begin
      rd_mux = port0_analog_enable_reg;
    end
    if (hit_aie1) begin
      rd_mux = pin_analog_enable[15:8];
    end
    if (hit_aie3) begin
      rd_mux = pin_analog_enable[31:24];
    end
  end

  // Registered read data; holds between reads
  always_ff @(posedge clock) begin
    if (!reset_n) begin
      rdata_reg <= RD_NONE;
    end else if (sfr_rd) begin
      rdata_reg <= rd_mux;
    end
  end

  assign sfr_rdata = rdata_reg;

  // ==========================================================
  // Register-level checks

  // Reset leaves the documented defaults in place
  property p_reset_vals;
    @(posedge clock) disable iff (!reset_n)
    $rose(reset_n)
    |-> input_sync_enable_reg == RST_SYNC
        && pin_pullup_enable_reg[3] == RST_PUP[3]
        && pin_pullup_enable_reg[0] == RST_PUP[0]
        && pin_direction_reg[2] == RST_DIR
        && pin_opendrain_select_reg[1] == RST_OD
        && pin_analog_enable == 32'h0000_0000;
  endproperty
  a_reset_vals: assert property (p_reset_vals) else $error("reset defaults wrong");

  // Sync register reads back only its low nibble
  property p_sync_rd;
    @(posedge clock) disable iff (!reset_n)
    sfr_wr && hit_sync ##1 !sfr_wr ##1 sfr_rd && hit_sync
    |=> sfr_rdata == ($past(sfr_wdata, 3) & 8'h0F);
  endproperty
  a_sync_rd: assert property (p_sync_rd) else $error("sync enable readback wrong");

  // Port 0 analog enables track all eight written bits
  property p_aie0;
    @(posedge clock) disable iff (!reset_n)
    sfr_wr && hit_aie0 |=> pin_analog_enable[7:0] == $past(sfr_wdata);
  endproperty
  a_aie0: assert property (p_aie0) else $error("port 0 analog enable wrong");

  // Port 1 keeps only bit 2
  property p_aie1;
    @(posedge clock) disable iff (!reset_n)
    sfr_wr && hit_aie1 |=> pin_analog_enable[15:8] == ($past(sfr_wdata) & AIE1_MASK);
  endproperty
  a_aie1: assert property (p_aie1) else $error("port 1 analog enable wrong");

  // Port 3 keeps only bit 0
  property p_aie3;
    @(posedge clock) disable iff (!reset_n)
    sfr_wr && hit_aie3 ##1 !sfr_wr ##1 sfr_rd && hit_aie3
    |=> sfr_rdata == ($past(sfr_wdata, 3) & AIE3_MASK);
  endproperty
  a_aie3: assert property (p_aie3) else $error("port 3 analog enable wrong");

  // Unmapped reads answer zero
  property p_unmapped;
    @(posedge clock) disable iff (!reset_n)
    sfr_rd && !(|{hit_data, hit_dir, hit_od, hit_pup, hit_sync, hit_aie0, hit_aie1, hit_aie3})
    |=> sfr_rdata == RD_NONE;
  endproperty
  a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");

endmodule
`default_nettype wire

// file: logic/gpd_pkg.sv
// Register map, reset values and sizes for the four-port GPIO block
package gpd_pkg;

  // ==========================================================
  // Sizes
  localparam int unsigned NUM_PORTS   = 4;
  localparam int unsigned PORT_W      = 8;
  localparam int unsigned SYNC_STAGES = 2;
  localparam int unsigned RD_LATENCY  = 1;

  typedef logic [7:0] gpd_byte_t;

  // ==========================================================
  // Special-function-register addresses
  localparam gpd_byte_t ADDR_DATA [NUM_PORTS] = '{8'h80, 8'h90, 8'hA0, 8'hB0};
  localparam gpd_byte_t ADDR_OD   [NUM_PORTS] = '{8'hA4, 8'hA5, 8'hA6, 8'hA7};
  localparam gpd_byte_t ADDR_DIR  [NUM_PORTS] = '{8'hAC, 8'hAD, 8'hAE, 8'hAF};
  localparam gpd_byte_t ADDR_PUP  [NUM_PORTS] = '{8'hB1, 8'hB2, 8'hB3, 8'hB4};
  localparam gpd_byte_t ADDR_SYNC = 8'hB6;
  localparam gpd_byte_t ADDR_AIE0 = 8'hE1;
  localparam gpd_byte_t ADDR_AIE1 = 8'hE2;
  localparam gpd_byte_t ADDR_AIE3 = 8'hE4;

  // ==========================================================
  // Field positions and masks
  localparam int unsigned AIE1_BIT  = 2;
  localparam int unsigned AIE3_BIT  = 0;
  localparam gpd_byte_t   AIE1_MASK = 8'h04;
  localparam gpd_byte_t   AIE3_MASK = 8'h01;

  // ==========================================================
  // Reset values
  localparam gpd_byte_t  RST_DATA = 8'hFF;
  localparam gpd_byte_t  RST_DIR  = 8'hFF;
  localparam gpd_byte_t  RST_OD   = 8'h00;
  localparam gpd_byte_t  RST_PUP [NUM_PORTS] = '{8'h00, 8'h00, 8'h00, 8'h0C};
  localparam logic [3:0] RST_SYNC = 4'h0;
  localparam gpd_byte_t  RST_AIE  = 8'h00;
  localparam gpd_byte_t  RD_NONE  = 8'h00;

endpackage

// file: logic/gpd_port_if.sv
// Interface carrying one port's settings and pad results between top and slice
`timescale 1ns/10ps
`default_nettype none
interface gpd_port_if;
  import gpd_pkg::*;

  // Settings from the register file
  gpd_byte_t data;
  gpd_byte_t dir;
  gpd_byte_t od;
  gpd_byte_t pup;
  logic      sync_en;
  gpd_byte_t sel;
  gpd_byte_t p_out;
  gpd_byte_t p_oe;
  gpd_byte_t pad_in;

  // Results toward pads and the read path
  gpd_byte_t rd_val;
  gpd_byte_t pad_out;
  gpd_byte_t pad_oe;
  gpd_byte_t pull_en;
  gpd_byte_t inbuf_en;

  modport ctrl  (output data, dir, od, pup, sync_en, sel, p_out, p_oe, pad_in,
                 input  rd_val, pad_out, pad_oe, pull_en, inbuf_en);
  modport slice (input  data, dir, od, pup, sync_en, sel, p_out, p_oe, pad_in,
                 output rd_val, pad_out, pad_oe, pull_en, inbuf_en);
endinterface
`default_nettype wire

// file: logic/gpd_pin_slice.sv
// One byte-wide port: input synchroniser, read source, drive and pull-up logic
`timescale 1ns/10ps
`default_nettype none
module gpd_pin_slice
  import gpd_pkg::*;
(
  // Clock and reset
  input  wire logic   clock,
  input  wire logic   reset_n,
  // Port settings and results
  gpd_port_if.slice   pif
);

  // ==========================================================
  // Input synchroniser
  gpd_byte_t sync_s1_reg;
  gpd_byte_t sync_s2_reg;
  gpd_byte_t sensed;
  gpd_byte_t gpio_oe;
  gpd_byte_t gpio_out;

  // Two stages; first stage is seen only by the second
  always_ff @(posedge clock) begin
    if (!reset_n) begin
      sync_s1_reg <= 8'h00;
      sync_s2_reg <= 8'h00;
    end else begin
      sync_s1_reg <= pif.pad_in;
      sync_s2_reg <= sync_s1_reg;
    end
  end

  // Synchronised or raw pad level
  assign sensed = pif.sync_en ? sync_s2_reg : pif.pad_in;

  // ==========================================================
  // Read source: pad when direction bit is one, register when pushing out
  assign pif.rd_val = (pif.dir & sensed)
                    | (~pif.dir & ~pif.od & pif.data);

  // ==========================================================
  // Drive: push-pull outputs follow data, open-drain only pulls low
  assign gpio_oe  = (~pif.od & ~pif.dir) | (pif.od & ~pif.data);
  assign gpio_out = pif.data & ~pif.od;

  // Peripheral takes the pin over when enabled
  assign pif.pad_oe  = (pif.sel & pif.p_oe) | (~pif.sel & gpio_oe);
  assign pif.pad_out = (pif.sel & pif.p_out) | (~pif.sel & gpio_out);

  // Any driven pin drops its pull-up to stop leakage
  assign pif.pull_en = pif.pup & ~pif.pad_oe;

  // Open-drain direction bit gates the input buffer only
  assign pif.inbuf_en = ~pif.od | pif.dir | pif.sel;

endmodule
`default_nettype wire

// file: verif/gpd_pad_model.sv
// Pad and board model that resolves each pin level fed back to the block
`timescale 1ns/10ps
`default_nettype none
module gpd_pad_model (
  // Clock
  input  wire logic        clock,
  // Block side
  input  wire logic [31:0] pad_out,
  input  wire logic [31:0] pad_oe,
  input  wire logic [31:0] pad_pullup_en,
  // Board side
  input  wire logic [31:0] ext_val,
  input  wire logic [31:0] ext_oe,
  output logic      [31:0] pad_in
);
  logic [31:0] last_reg;

  // ==========================================================
  // Block drive wins over the board; a floating pin without pull-up
  // shows the inverse of its last level so a stale value never passes
  assign pad_in = (pad_oe & pad_out) | (~pad_oe & ext_oe & ext_val)
                | (~pad_oe & ~ext_oe & (pad_pullup_en | ~last_reg));

  // Last resolved level
  always_ff @(posedge clock) begin
    last_reg <= pad_in;
  end
endmodule
`default_nettype wire

// file: verif/tb_top.sv
// Self-checking bench for the four-port GPIO block against a register model
`timescale 1ns/10ps
`default_nettype none
module tb_top;
  import gpd_pkg::*;
  logic        clock, reset_n, sfr_wr, sfr_rd;
  logic [7:0]  sfr_addr, sfr_wdata, sfr_rdata, rv;
  logic [31:0] pad_in, pad_out, pad_oe, pad_pullup_en, pad_inbuf_en, pin_analog_enable;
  logic [31:0] periph_sel, periph_out, periph_oe, ext_val, ext_oe, rng;
  logic [7:0]  m_data [4], m_dir [4], m_od [4], m_pup [4], m_aie [3], addrs [20], q [3];
  logic [7:0]  m_sync;
  int          bad_count, total_checks, i, p;

  gpd_top gpd_top_i (.clock(clock), .reset_n(reset_n), .sfr_addr(sfr_addr), .sfr_wdata(sfr_wdata),
    .sfr_wr(sfr_wr), .sfr_rd(sfr_rd), .sfr_rdata(sfr_rdata), .pad_in(pad_in), .pad_out(pad_out),
    .pad_oe(pad_oe), .pad_pullup_en(pad_pullup_en), .pad_inbuf_en(pad_inbuf_en),
    .pin_analog_enable(pin_analog_enable), .periph_sel(periph_sel), .periph_out(periph_out),
    .periph_oe(periph_oe));
  gpd_pad_model gpd_pad_model_i (.clock(clock), .pad_out(pad_out), .pad_oe(pad_oe),
    .pad_pullup_en(pad_pullup_en), .ext_val(ext_val), .ext_oe(ext_oe), .pad_in(pad_in));

  // ==========================================================
  // Clock, random source, compare and close
  initial begin
    clock = 1'b0;
    forever #4 clock = ~clock;
  end

  function automatic logic [31:0] rnd();
    rng = rng ^ (rng << 13);
    rng = rng ^ (rng >> 17);
    rng = rng ^ (rng << 5);
    return rng;
  endfunction

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      bad_count++;
      $display("ERROR %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic end_sim();
    $display("checks %0d mismatches %0d", total_checks, bad_count);
    if (bad_count == 0 && total_checks > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  // ==========================================================
  // Model: read value of a data register from direction, mode and pads
  function automatic logic [7:0] port_rd(input int k);
    logic [7:0] oe, lvl;
    oe  = (m_od[k] & ~m_data[k]) | (~m_od[k] & ~m_dir[k]);
    lvl = (oe & ~m_od[k] & m_data[k]) | (~oe & ext_oe[8*k +: 8] & ext_val[8*k +: 8])
        | (~oe & ~ext_oe[8*k +: 8] & m_pup[k]);
    return (m_dir[k] & lvl) | (~m_dir[k] & ~m_od[k] & m_data[k]);
  endfunction

  function automatic logic [7:0] exp_reg(input logic [7:0] a);
    logic [7:0] r;
    r = 8'h00;
    for (int k = 0; k < 4; k++) begin
      if (a == ADDR_DATA[k]) r = port_rd(k);
      if (a == ADDR_DIR[k]) r = m_dir[k];
      if (a == ADDR_OD[k]) r = m_od[k];
      if (a == ADDR_PUP[k]) r = m_pup[k];
    end
    if (a == ADDR_SYNC) r = m_sync;
    if (a == ADDR_AIE0) r = m_aie[0];
    if (a == ADDR_AIE1) r = m_aie[1];
    if (a == ADDR_AIE3) r = m_aie[2];
    return r;
  endfunction

  // Register access; each begins one negedge later so strobes never double-assign
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge clock);
    sfr_addr  = a;
    sfr_wdata = d;
    sfr_wr    = 1'b1;
    @(negedge clock);
    sfr_wr = 1'b0;
    for (int k = 0; k < 4; k++) begin
      if (a == ADDR_DATA[k]) m_data[k] = d;
      if (a == ADDR_DIR[k]) m_dir[k] = d;
      if (a == ADDR_OD[k]) m_od[k] = d;
      if (a == ADDR_PUP[k]) m_pup[k] = d;
    end
    if (a == ADDR_SYNC) m_sync = d & 8'h0F;
    if (a == ADDR_AIE0) m_aie[0] = d;
    if (a == ADDR_AIE1) m_aie[1] = d & AIE1_MASK;
    if (a == ADDR_AIE3) m_aie[2] = d & AIE3_MASK;
  endtask

  task automatic rdchk(input logic [7:0] a);
    @(negedge clock);
    sfr_addr = a;
    sfr_rd   = 1'b1;
    @(negedge clock);
    rv     = sfr_rdata;
    sfr_rd = 1'b0;
    chk(32'(rv), 32'(exp_reg(a)));
  endtask

  // Pads expected from the model; pull-up follows the final drive enable
  task automatic check_pads();
    logic [31:0] goe, gout, pup, bufe, oe, ae;
    for (int k = 0; k < 4; k++) begin
      goe[8*k +: 8]  = (m_od[k] & ~m_data[k]) | (~m_od[k] & ~m_dir[k]);
      gout[8*k +: 8] = ~m_od[k] & m_data[k];
      pup[8*k +: 8]  = m_pup[k];
      bufe[8*k +: 8] = ~m_od[k] | m_dir[k];
    end
    oe     = (periph_sel & periph_oe) | (~periph_sel & goe);
    ae     = {24'h0, m_aie[0]};
    ae[10] = m_aie[1][2];
    ae[24] = m_aie[2][0];
    chk(pad_oe, oe);
    chk(pad_out & oe, ((periph_sel & periph_out) | (~periph_sel & gout)) & oe);
    chk(pad_pullup_en, pup & ~oe);
    chk(pad_inbuf_en, bufe | periph_sel);
    chk(pin_analog_enable, ae);
  endtask

  // Change port 1 pads and read three times back to back
  task automatic burst(input logic [7:0] v);
    @(negedge clock);
    ext_val[15:8] = 8'h5A;
    repeat (4) @(negedge clock);
    ext_val[15:8] = v;
    sfr_addr      = ADDR_DATA[1];
    sfr_rd        = 1'b1;
    for (int k = 0; k < 3; k++) begin
      @(negedge clock);
      q[k] = sfr_rdata;
    end
    sfr_rd = 1'b0;
  endtask

  // Hang guard
  initial begin
    repeat (20000) @(posedge clock);
    bad_count++;
    end_sim();
  end

  // ==========================================================
  // Main sequence
  initial begin
    rng = 32'h5FB7;
    {reset_n, sfr_wr, sfr_rd, sfr_addr, sfr_wdata} = '0;
    {periph_sel, periph_out, periph_oe} = '0;
    ext_oe  = '1;
    ext_val = rnd();
    for (p = 0; p < 4; p++) begin
      {m_data[p], m_dir[p], m_od[p], m_pup[p]} = {RST_DATA, RST_DIR, RST_OD, RST_PUP[p]};
      {addrs[p], addrs[4+p], addrs[8+p], addrs[12+p]} = {ADDR_DATA[p], ADDR_DIR[p], ADDR_OD[p], ADDR_PUP[p]};
    end
    {m_sync, m_aie[0], m_aie[1], m_aie[2]} = '0;
    {addrs[16], addrs[17], addrs[18], addrs[19]} = {ADDR_SYNC, ADDR_AIE0, ADDR_AIE1, ADDR_AIE3};
    repeat (4) @(posedge clock);
    @(negedge clock);
    reset_n = 1'b1;
    // Reset values of every control register
    check_pads();
    for (p = 4; p < 20; p++) rdchk(addrs[p]);
    // Floating pin on port 3 held high by its reset pull-up
    ext_oe = 32'hFBFF_FFFF;
    rdchk(ADDR_DATA[3]);
    ext_oe = '1;
    // Random register traffic, unimplemented bits dropped
    for (i = 0; i < 40; i++) begin
      p = int'(rnd() % 20);
      wr(addrs[p], 8'(rnd()));
      // Synchronised ports need two cycles to see a new drive
      if (p < 4) repeat (2) @(negedge clock);
      rdchk(addrs[p]);
      check_pads();
    end
    wr(8'hC0, 8'hFF);
    rdchk(8'hC0);
    // Direction before data, push-pull then open-drain
    for (i = 0; i < 16; i++) begin
      p       = i % 4;
      ext_val = rnd();
      wr(ADDR_OD[p], (i < 8) ? 8'h00 : 8'(rnd()));
      wr(ADDR_DIR[p], 8'(rnd()));
      wr(ADDR_DATA[p], 8'(rnd()));
      wr(ADDR_PUP[p], 8'(rnd()));
      check_pads();
      rdchk(ADDR_DATA[p]);
    end
    // Peripherals take over their pins
    for (i = 0; i < 8; i++) begin
      periph_sel = rnd();
      periph_out = rnd();
      periph_oe  = rnd();
      @(negedge clock);
      check_pads();
    end
    periph_sel = '0;
    // Two-stage synchroniser against raw pad reads
    wr(ADDR_DIR[1], 8'hFF);
    wr(ADDR_OD[1], 8'h00);
    wr(ADDR_SYNC, 8'hF2);
    rdchk(ADDR_SYNC);
    burst(8'hA5);
    chk(32'(q[0]), 32'h5A);
    chk(32'(q[1]), 32'h5A);
    chk(32'(q[2]), 32'hA5);
    wr(ADDR_SYNC, 8'h00);
    burst(8'hC3);
    chk(32'(q[0]), 32'hC3);
    chk(32'(q[2]), 32'hC3);
    // Analog preparation of port 0 pin 3, then channels released
    wr(ADDR_OD[0], 8'h08);
    wr(ADDR_DATA[0], m_data[0] | 8'h08);
    wr(ADDR_DIR[0], m_dir[0] & 8'hF7);
    wr(ADDR_AIE0, 8'h08);
    wr(ADDR_AIE1, 8'hFF);
    wr(ADDR_AIE3, 8'hFF);
    rdchk(ADDR_AIE3);
    check_pads();
    rdchk(ADDR_DATA[0]);
    rdchk(ADDR_AIE1);
    rdchk(ADDR_AIE3);
    wr(ADDR_AIE0, 8'h00);
    wr(ADDR_AIE1, 8'h00);
    wr(ADDR_AIE3, 8'h00);
    check_pads();
    end_sim();
  end
endmodule
`default_nettype wire
